/* rtl/pwr_sup_regs.svh */
// Register offsets, field positions, reset values and timing counts of the supervisor.
// Assumes a 50 MHz always-on clock and a battery monitor that reports millivolts.
`ifndef PWR_SUP_REGS_SVH
`define PWR_SUP_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_STATUS       16'h1002
`define ADDR_WAKE_CTRL    16'h100F
`define ADDR_SHUTDOWN     16'h1010
`define ADDR_PRESS_TIME   16'h1011
`define ADDR_TIME         16'h1013
`define ADDR_ALARM        16'h1017
`define ADDR_IRQ_MASK     16'h1020

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define STATUS_CRIT_BIT   7
`define STATUS_SHORT_BIT  4
`define STATUS_ON_BIT     0
`define WAKE_CHG_START    0
`define WAKE_CHG_END      1
`define PRESS_TIME_RESET  8'h64
`define WAKE_CTRL_RESET   8'h00
`define IRQ_MASK_RESET    8'h00
`define STICKY_MASK       8'h90

// ----------------------------------------------------------------------------
// Voltages and times
// ----------------------------------------------------------------------------
`define BATT_CRIT_MV      16'h0CE4
`define BATT_LOW_MV       16'h0DAC
`define CLOCK_HZ          50000000
`define TICK_MS           10
`define TICK_CYCLES       (`CLOCK_HZ / 1000 * `TICK_MS)
`define SECOND_CYCLES     (`CLOCK_HZ)
`define DEBOUNCE_MS       5
`define DEBOUNCE_CYCLES   (`CLOCK_HZ / 1000 * `DEBOUNCE_MS)
`define MIN_ON_MS         20
`define MIN_ON_TICKS      (`MIN_ON_MS / `TICK_MS)
`define HARD_OFF_MS       5000
`define HARD_OFF_TICKS    (`HARD_OFF_MS / `TICK_MS)
`define CRIT_OFF_MS       9000
`define CRIT_OFF_TICKS    (`CRIT_OFF_MS / `TICK_MS)

`endif

/* rtl/pwr_sup_pkg.sv */
// Types shared by the supervisor modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pwr_sup_pkg;

  // --------------------------------------------------------------------------
  // Power state, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_ON   = 3'b010,
    ST_HOLD = 3'b100
  } power_state_t;

  typedef logic [9:0] press_ticks_t;

endpackage : pwr_sup_pkg

/* rtl/press_if.sv */
// Debounced button events passed from the filter to the supervisor.
// Assumes both ends run on the same always-on clock.
interface press_if;
  logic pressed;     // Debounced level, high while held
  logic press_start; // One-cycle pulse on a settled press
  logic press_end;   // One-cycle pulse on a settled release

  modport filter     (output pressed, output press_start, output press_end);
  modport supervisor (input pressed, input press_start, input press_end);
endinterface : press_if

/* rtl/press_filter.sv */
// Contact-bounce filter for the power button.
// Assumes the raw level is already synchronised to clock.
`include "pwr_sup_regs.svh"
module press_filter
  import pwr_sup_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic raw_pressed,
  press_if.filter   btn
);
  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);

  logic [CW-1:0] settle;

  // ---------------------------------------------------------------------------
  // Level must hold steady for the whole settle time before it is accepted
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle          <= '0;
      btn.pressed     <= 1'b0;
      btn.press_start <= 1'b0;
      btn.press_end   <= 1'b0;
    end else begin
      btn.press_start <= 1'b0;
      btn.press_end   <= 1'b0;
      if (raw_pressed == btn.pressed) begin
        settle <= '0;
      end else if (settle == CW'(DEBOUNCE_CYCLES - 1)) begin
        settle          <= '0;
        btn.pressed     <= raw_pressed;
        btn.press_start <= raw_pressed;
        btn.press_end   <= !raw_pressed;
      end else begin
        settle <= settle + 1'b1;
      end
    end
  end

endmodule : press_filter

/* rtl/board_power_supervisor.sv */
// Always-on power supervisor: switched rail enables, wake sources, power-off sources.
// Assumes battery_mv comes from a monitor on the same clock; pins are asynchronous.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`include "pwr_sup_regs.svh"

// How it works
// - Always-on logic drives enables of switched logic rail and switched battery rail.
// - Button pin is active low: idle high, pressed when grounded.
// - Holding the button for the programmed time, but at least 20 ms, powers the rails on unless the battery is low.
// - RTC reaching the alarm value powers the rails on.
// - Separate enables let charge start or charge end power the rails on.
// - A host write to the shutdown register switches the rails off.
// - Short presses while powered are reported to the host.
// - A five second hold forces the rails off without host action.
// - Battery below 3.3V switches the rails off.
// - A readable warning is raised before the critical-battery shutdown.
// - Battery at 3.5V or lower blocks every power-on source.
// - Warning is status bit 7; rails go off within ten seconds after it.
// - Short-press threshold is 8 bits in 10 ms units, reset value 100.
// - Status bit 4 sets on release after a press above threshold, below five seconds.
module board_power_supervisor
  import pwr_sup_pkg::*;
#(
  parameter int TICK_CYCLES     = `TICK_CYCLES,
  parameter int SECOND_CYCLES   = `SECOND_CYCLES,
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        power_button_n,
  input  wire logic        charging,
  input  wire logic        charge_done,
  input  wire logic [15:0] battery_mv,
  output logic             switched_logic_rail,
  output logic             switched_battery_rail,
  output logic             irq
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int SECW = $clog2(SECOND_CYCLES + 1);

  power_state_t state;
  power_state_t next_state;
  press_if      btn ();

  logic [1:0]   button_sync;
  logic [2:0]   charging_sync;
  logic [2:0]   done_sync;
  logic [TW-1:0] tick_cnt;
  logic          tick;
  logic [SECW-1:0] sec_cnt;
  logic          sec_tick;
  press_ticks_t  press_ticks;
  logic          press_valid;
  logic [7:0]    press_time_setting;
  logic [7:0]    wake_ctrl;
  logic [7:0]    irq_mask;
  logic [7:0]    status;
  logic [31:0]   rtc_time;
  logic [31:0]   alarm_value;
  logic          alarm_match_d;
  logic          crit_active;
  press_ticks_t  crit_ticks;
  press_ticks_t  on_thresh;
  logic          batt_low;
  logic          batt_crit;
  logic          button_on;
  logic          alarm_hit;
  logic          chg_start_wake;
  logic          chg_end_wake;
  logic          wake_req;
  logic          shutdown_req;
  logic          hard_off;
  logic          crit_expired;
  logic          short_press;
  logic          status_read;
  logic [7:0]    status_view;

  // ---------------------------------------------------------------------------
  // Pin synchronisers; bit 2 of the charger flags keeps the previous sample for edge detection
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      button_sync   <= 2'h0;
      charging_sync <= 3'h0;
      done_sync     <= 3'h0;
    end else begin
      button_sync   <= {button_sync[0], !power_button_n};
      charging_sync <= {charging_sync[1:0], charging};
      done_sync     <= {done_sync[1:0], charge_done};
    end
  end

  press_filter #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) u_filter (
    .clock       (clock),
    .resetn      (resetn),
    .raw_pressed (button_sync[1]),
    .btn         (btn)
  );

  // ---------------------------------------------------------------------------
  // 10 ms tick and one second tick
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TW'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sec_cnt  <= '0;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= (sec_cnt == SECW'(SECOND_CYCLES - 1));
      sec_cnt  <= (sec_cnt == SECW'(SECOND_CYCLES - 1)) ? '0 : sec_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Press duration in 10 ms units, saturating
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      press_ticks <= '0;
    end else if (btn.press_start) begin
      press_ticks <= '0;
    end else if (btn.pressed && tick && press_ticks != '1) begin
      press_ticks <= press_ticks + 1'b1;
    end
  end

  // Only a press that began while powered counts toward short press or hard off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      press_valid <= 1'b0;
    end else if (state != ST_ON || btn.press_end) begin
      press_valid <= 1'b0;
    end else if (btn.press_start) begin
      press_valid <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------------
  assign batt_low       = battery_mv <= `BATT_LOW_MV;
  assign batt_crit      = battery_mv < `BATT_CRIT_MV;
  assign on_thresh      = (press_time_setting < 8'(`MIN_ON_TICKS)) ?
                          10'(`MIN_ON_TICKS) : {2'h0, press_time_setting};
  assign button_on      = btn.pressed && press_ticks >= on_thresh;
  assign alarm_hit      = (rtc_time == alarm_value) && !alarm_match_d;
  assign chg_start_wake = wake_ctrl[`WAKE_CHG_START] && charging_sync[1]
                          && !charging_sync[2];
  assign chg_end_wake   = wake_ctrl[`WAKE_CHG_END] && done_sync[1] && !done_sync[2];
  assign wake_req       = button_on || alarm_hit || chg_start_wake || chg_end_wake;
  assign shutdown_req   = wr && addr == `ADDR_SHUTDOWN;
  assign hard_off       = press_valid && press_ticks >= 10'(`HARD_OFF_TICKS);
  assign crit_expired   = crit_active && crit_ticks >= 10'(`CRIT_OFF_TICKS);
  assign short_press    = btn.press_end && press_valid && state == ST_ON
                          && press_ticks > {2'h0, press_time_setting}
                          && press_ticks < 10'(`HARD_OFF_TICKS);
  assign status_read    = rd && addr == `ADDR_STATUS;

  // ---------------------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (!batt_low && wake_req) begin
          next_state = ST_ON;
        end
      end
      ST_ON: begin
        if (hard_off) begin
          next_state = ST_HOLD;
        end else if (shutdown_req || crit_expired) begin
          next_state = ST_OFF;
        end
      end
      ST_HOLD: begin
        if (!btn.pressed) begin
          next_state = ST_OFF;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Both switched rails follow the state, from a flop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      switched_logic_rail   <= 1'b0;
      switched_battery_rail <= 1'b0;
    end else begin
      switched_logic_rail   <= (state == ST_ON);
      switched_battery_rail <= (state == ST_ON);
    end
  end

  // ---------------------------------------------------------------------------
  // Critical battery: warning then timed shutdown
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      crit_active <= 1'b0;
      crit_ticks  <= '0;
    end else if (state != ST_ON) begin
      crit_active <= 1'b0;
      crit_ticks  <= '0;
    end else if (batt_crit || crit_active) begin
      crit_active <= 1'b1;
      if (crit_active && tick) begin
        crit_ticks <= crit_ticks + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sticky status; a read clears it, a new event in the same cycle wins
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status <= 8'h00;
    end else begin
      status <= (status_read ? 8'h00 : status)
              | ((state == ST_ON && batt_crit) ? 8'h80 : 8'h00)
              | (short_press ? 8'h10 : 8'h00);
    end
  end

  assign status_view = (status & `STICKY_MASK)
                     | ((state == ST_ON) ? 8'h01 : 8'h00);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_mask);
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      press_time_setting <= `PRESS_TIME_RESET;
      wake_ctrl          <= `WAKE_CTRL_RESET;
      irq_mask           <= `IRQ_MASK_RESET;
    end else if (wr) begin
      if (addr == `ADDR_PRESS_TIME) press_time_setting <= wdata;
      if (addr == `ADDR_WAKE_CTRL) wake_ctrl <= wdata;
      if (addr == `ADDR_IRQ_MASK) irq_mask <= wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // RTC and alarm; byte 0 of each is the most significant
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rtc_time    <= 32'h0;
      alarm_value <= 32'h0;
    end else begin
      if (sec_tick) begin
        rtc_time <= rtc_time + 32'h1;
      end
      for (int i = 0; i < 4; i++) begin
        if (wr && addr == `ADDR_TIME + 16'(i)) rtc_time[31 - 8 * i -: 8] <= wdata;
        if (wr && addr == `ADDR_ALARM + 16'(i)) alarm_value[31 - 8 * i -: 8] <= wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alarm_match_d <= 1'b1;
    end else begin
      alarm_match_d <= (rtc_time == alarm_value);
    end
  end

  // ---------------------------------------------------------------------------
  // Read data, valid in the cycle after the strobe only
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (!rd) begin
      rdata <= 8'h00;
    end else begin
      rdata <= 8'h00;
      case (addr)
        `ADDR_STATUS:     rdata <= status_view;
        `ADDR_WAKE_CTRL:  rdata <= wake_ctrl;
        `ADDR_PRESS_TIME: rdata <= press_time_setting;
        `ADDR_IRQ_MASK:   rdata <= irq_mask;
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (addr == `ADDR_TIME + 16'(i)) rdata <= rtc_time[31 - 8 * i -: 8];
            if (addr == `ADDR_ALARM + 16'(i)) rdata <= alarm_value[31 - 8 * i -: 8];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_rails_follow_state: assert property (
    (state == ST_ON) |=> (switched_logic_rail && switched_battery_rail))
    else $error("rails not on while state is on");
  a_shutdown_rails_off: assert property (
    (state == ST_ON && shutdown_req && !hard_off) |=> ##1 !switched_logic_rail)
    else $error("shutdown write did not drop rails");
  a_low_batt_block: assert property (
    (state != ST_ON && batt_low) |=> !(state == ST_ON))
    else $error("power on with low battery");
  a_crit_warns: assert property (
    (state == ST_ON && batt_crit) |=> status[`STATUS_CRIT_BIT])
    else $error("critical warning not raised");
  a_crit_bounded: assert property (
    (state == ST_ON) |-> (crit_ticks <= 10'(`CRIT_OFF_TICKS)))
    else $error("critical shutdown overdue");
  a_hard_off_hold: assert property (
    (state == ST_ON && hard_off) |=> (state == ST_HOLD) ##1 !switched_logic_rail)
    else $error("long press did not force off");
  a_hold_no_reon: assert property (
    (state == ST_HOLD && btn.pressed) |=> (state != ST_ON))
    else $error("held button re-enabled power");
  a_short_flag: assert property (
    short_press |=> status[`STATUS_SHORT_BIT])
    else $error("short press not flagged");
  a_button_on: assert property (
    (state == ST_OFF && button_on && !batt_low) |=> ##1 switched_logic_rail)
    else $error("button press did not power on");

  c_button_on:  cover property ((state == ST_OFF) ##1 (state == ST_ON));
  c_short:      cover property (short_press);
  c_hard_off:   cover property ((state == ST_HOLD) ##1 (state == ST_OFF));
  c_crit_off:   cover property (crit_expired && state == ST_ON);

endmodule : board_power_supervisor

/* sim/board_partner.sv */
// Far side of the supervisor: power button, charger status and battery monitor.
// Assumes the bench sets the wanted levels; the monitor shares the always-on clock.
module board_partner (
  input  wire logic        clock,
  input  wire logic        press,
  input  wire logic        chg,
  input  wire logic        full,
  input  wire logic [15:0] level_mv,
  output logic             power_button_n,
  output logic             charging,
  output logic             charge_done,
  output logic [15:0]      battery_mv
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // Button contact and charger flags
  // --------------------------------------------------------------------------
  // Pull-up holds the pin high; the closed contact grounds it
  assign power_button_n = press ? 1'b0 : 1'b1;
  assign charging       = chg;
  assign charge_done    = full;

  // --------------------------------------------------------------------------
  // Battery monitor
  // --------------------------------------------------------------------------
  // New readings appear just after a clock edge, as a synchronous monitor would
  always @(posedge clock) begin
    battery_mv <= level_mv;
  end
endmodule : board_partner

/* sim/tb_board_power_supervisor.sv */
// Self-checking bench of the power supervisor through its register port and pins.
// Assumes shortened tick, second and debounce counts set at the instance.
`include "pwr_sup_regs.svh"
module tb_board_power_supervisor
  import pwr_sup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK  = 4;
  localparam int LIMIT = 40000;

  logic        clock, resetn, wr, rd, press, chg, full;
  logic [15:0] addr, level_mv, battery_mv;
  logic [7:0]  wdata, rdata;
  logic        power_button_n, charging, charge_done;
  logic        switched_logic_rail, switched_battery_rail, irq;
  int          miscompares, total_checks, cycles;

  board_power_supervisor #(.TICK_CYCLES(TICK), .SECOND_CYCLES(16), .DEBOUNCE_CYCLES(3)) uut (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .power_button_n(power_button_n), .charging(charging),
    .charge_done(charge_done), .battery_mv(battery_mv),
    .switched_logic_rail(switched_logic_rail),
    .switched_battery_rail(switched_battery_rail), .irq(irq));

  board_partner far_side (
    .clock(clock), .press(press), .chg(chg), .full(full), .level_mv(level_mv),
    .power_button_n(power_button_n), .charging(charging), .charge_done(charge_done),
    .battery_mv(battery_mv));

  // --------------------------------------------------------------------------
  // Clock and hang guard
  // --------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Cuts a hung run short as a failure
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      close_out();
    end
  end

  // --------------------------------------------------------------------------
  // Access and compare tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    chk(rdata & m, exp);
  endtask : rd_reg

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : hold

  // Waits a bounded time for the logic rail to reach the level, then checks both rails
  task automatic wait_rails(input logic val, input int lim);
    int n;
    n = 0;
    while (switched_logic_rail !== val && n < lim) begin
      hold(1);
      n++;
    end
    chk({7'h00, switched_logic_rail}, {7'h00, val});
    chk({7'h00, switched_battery_rail}, {7'h00, val});
  endtask : wait_rails

  task automatic press_on();
    @(posedge clock);
    press <= 1'b1;
    wait_rails(1'b1, 200);
    @(posedge clock);
    press <= 1'b0;
    hold(20);
  endtask : press_on

  task automatic shut_down();
    wr_reg(`ADDR_SHUTDOWN, 8'h00);
    wait_rails(1'b0, 3);
  endtask : shut_down

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // --------------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------------
  initial begin
    resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 16'h0000; wdata = 8'h00;
    press = 1'b0; chg = 1'b0; full = 1'b0; level_mv = 16'h0E74;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    // Reset values, read-only and unmapped places
    rd_reg(`ADDR_PRESS_TIME, 8'h64, 8'hFF);
    rd_reg(`ADDR_WAKE_CTRL, 8'h00, 8'hFF);
    rd_reg(`ADDR_IRQ_MASK, 8'h00, 8'hFF);
    wr_reg(`ADDR_STATUS, 8'hFF);
    rd_reg(`ADDR_STATUS, 8'h00, 8'hFF);
    rd_reg(16'h1030, 8'h00, 8'hFF);
    wr_reg(`ADDR_PRESS_TIME, 8'h02);
    rd_reg(`ADDR_PRESS_TIME, 8'h02, 8'hFF);
    wait_rails(1'b0, 0);
    $display("test reset done");
    // Bouncing contact never settles, so no power-on
    repeat (30) begin
      @(posedge clock);
      press <= ~press;
    end
    @(posedge clock);
    press <= 1'b0;
    hold(20);
    wait_rails(1'b0, 0);
    // Battery at the low limit blocks a long press
    @(posedge clock);
    level_mv <= 16'h0DAC;
    @(posedge clock);
    press <= 1'b1;
    hold(100);
    wait_rails(1'b0, 0);
    // Release first, so a still-held press cannot wake once the battery recovers
    @(posedge clock);
    press <= 1'b0;
    hold(20);
    wait_rails(1'b0, 0);
    @(posedge clock);
    level_mv <= 16'h0E74;
    hold(20);
    $display("test refusals done");
    // Power on by button, then short press with interrupt
    press_on();
    rd_reg(`ADDR_STATUS, 8'h01, 8'hFF);
    wr_reg(`ADDR_IRQ_MASK, 8'h90);
    @(posedge clock);
    press <= 1'b1;
    hold(40);
    @(posedge clock);
    press <= 1'b0;
    hold(10);
    chk({7'h00, irq}, 8'h01);
    rd_reg(`ADDR_STATUS, 8'h11, 8'hFF);
    hold(2);
    chk({7'h00, irq}, 8'h00);
    rd_reg(`ADDR_STATUS, 8'h01, 8'hFF);
    shut_down();
    hold(50);
    wait_rails(1'b0, 0);
    $display("test button done");
    // Charge start and charge end wakes
    wr_reg(`ADDR_WAKE_CTRL, 8'h01);
    rd_reg(`ADDR_WAKE_CTRL, 8'h01, 8'hFF);
    @(posedge clock);
    chg <= 1'b1;
    wait_rails(1'b1, 20);
    shut_down();
    @(posedge clock);
    chg <= 1'b0;
    wr_reg(`ADDR_WAKE_CTRL, 8'h02);
    @(posedge clock);
    full <= 1'b1;
    wait_rails(1'b1, 20);
    shut_down();
    @(posedge clock);
    full <= 1'b0;
    wr_reg(`ADDR_WAKE_CTRL, 8'h00);
    $display("test charge done");
    // Alarm five seconds after the counter is cleared
    wr_reg(16'h101A, 8'h05);
    wr_reg(16'h1016, 8'h00);
    wr_reg(16'h1015, 8'h00);
    wr_reg(16'h1014, 8'h00);
    wr_reg(16'h1013, 8'h00);
    wait_rails(1'b1, 200);
    $display("test alarm done");
    // Critical battery: warning first, rails off later
    @(posedge clock);
    level_mv <= 16'h0CE3;
    hold(5);
    rd_reg(`ADDR_STATUS, 8'h81, 8'h81);
    wait_rails(1'b0, `CRIT_OFF_TICKS * TICK + 100);
    hold(50);
    wait_rails(1'b0, 0);
    @(posedge clock);
    level_mv <= 16'h0E74;
    hold(5);
    $display("test critical done");
    // Long hold forces off; held button keeps rails off
    press_on();
    @(posedge clock);
    press <= 1'b1;
    hold(1600);
    wait_rails(1'b1, 0);
    wait_rails(1'b0, 600);
    hold(300);
    wait_rails(1'b0, 0);
    @(posedge clock);
    press <= 1'b0;
    hold(20);
    rd_reg(`ADDR_STATUS, 8'h00, 8'h10);
    $display("test hard off done");
    close_out();
  end
endmodule : tb_board_power_supervisor
